// file: flash_status_register.sv
// Status register and program/erase sequencing of a NOR flash bank array
// How it works
// - Ready flag low while controller active in any bank, high when idle.
// - After suspend, ready stays low until the engine reports it has paused.
// - Erase-suspended flag set when suspend halted an erase, awaiting resume.
// - Erase suspend may complete instead; host trusts flag only when ready.
// - Resume command clears the erase-suspended flag.
// - Erase still failing after maximum pulses sets erase-error flag.
// - Blank check finding any word other than all ones sets erase-error flag.
// - Erase-error sticky until clear or reset; new erase then appears to fail.
// - Program still failing after maximum pulses sets program-error flag.
// - Programming a one over a zero flags error only at high supply level.
// - Program-error sticky until clear or reset; new program appears to fail.
// - Supply validity sampled only at start of each program or erase.
// - Supply below lockout sets supply-error flag and refuses the operation.
// - Program-suspended flag set on paused program; may finish instead.
// - Resume command clears the program-suspended flag.
// - Program or erase on locked block sets protection-error and aborts.
// - Protection and supply errors sticky; new program or erase appears to fail.
// - While busy, bank flag low for addressed bank, high for another bank.
// - In buffered factory mode bank flag low when next word can be taken.
// - Status latched when read cycle starts, held until it ends.
// - During program or erase, reads return status unless read-array issued.
`timescale 1ns/1ns
`default_nettype none
module flash_status_register #(
  parameter int unsigned BANK_W = flash_status_pkg::BANK_W,
  parameter int unsigned DATA_W = flash_status_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_program,
  input wire logic cmd_erase,
  input wire logic cmd_blank_check,
  input wire logic cmd_suspend,
  input wire logic cmd_resume,
  input wire logic cmd_clear_status,
  input wire logic cmd_read_array,
  input wire logic cmd_read_status,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic target_block_locked,
  input wire logic supply_above_lockout,
  input wire logic programming_supply_high_level,
  input wire logic engine_done,
  input wire logic engine_paused,
  input wire logic erase_fail_max,
  input wire logic program_fail_max,
  input wire logic program_overwrite_attempt,
  input wire logic blank_word_valid,
  input wire logic [DATA_W-1:0] blank_word,
  input wire logic buffered_factory_program_mode,
  input wire logic bfp_word_ready,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic [BANK_W-1:0] bus_bank,
  input wire logic [DATA_W-1:0] array_data,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic engine_start,
  output logic engine_is_erase,
  output logic engine_is_blank_check,
  output logic engine_suspend,
  output logic engine_resume,
  output logic [flash_status_pkg::STATUS_W-1:0] program_erase_status
);
  flash_status_pkg::ctrl_state_t state, next_state;
  logic op_erase, next_op_erase;
  logic op_blank, next_op_blank;
  logic [BANK_W-1:0] active_bank, next_active_bank;
  logic erase_suspended_flag, next_erase_suspended_flag;
  logic program_suspended_flag, next_program_suspended_flag;
  logic erase_error_flag, next_erase_error_flag;
  logic program_error_flag, next_program_error_flag;
  logic supply_error_flag, next_supply_error_flag;
  logic protection_error_flag, next_protection_error_flag;
  logic status_mode, next_status_mode;
  logic read_active_q, next_read_active_q;
  logic [DATA_W-1:0] read_word, next_read_word;
  logic next_engine_start, next_engine_suspend, next_engine_resume;
  logic controller_ready_flag, bank_write_flag;
  logic read_active, read_start, start_req, start_blocked;
  logic [flash_status_pkg::STATUS_W-1:0] status_now;

  // Live status vector
  always_comb
  begin
    controller_ready_flag = (state == flash_status_pkg::ST_IDLE) ||
      (state == flash_status_pkg::ST_SUSPENDED);
    if (controller_ready_flag)
      bank_write_flag = 1'b0;
    else if (buffered_factory_program_mode)
      bank_write_flag = ~bfp_word_ready;
    else
      bank_write_flag = (bus_bank != active_bank);
    status_now = '0;
    status_now[flash_status_pkg::BIT_READY] = controller_ready_flag;
    status_now[flash_status_pkg::BIT_ERASE_SUSP] = erase_suspended_flag;
    status_now[flash_status_pkg::BIT_ERASE_ERR] = erase_error_flag;
    status_now[flash_status_pkg::BIT_PROG_ERR] = program_error_flag;
    status_now[flash_status_pkg::BIT_SUPPLY_ERR] = supply_error_flag;
    status_now[flash_status_pkg::BIT_PROG_SUSP] = program_suspended_flag;
    status_now[flash_status_pkg::BIT_PROTECT_ERR] = protection_error_flag;
    status_now[flash_status_pkg::BIT_BANK_WRITE] = bank_write_flag;
  end

  assign read_active = ~ce_n & ~oe_n;
  assign read_start = read_active & ~read_active_q;
  assign start_req = cmd_program | cmd_erase | cmd_blank_check;
  // A pending supply or protection error, or the matching program/erase error, makes a new command look failed rather than run
  assign start_blocked = supply_error_flag | protection_error_flag |
    (cmd_program ? program_error_flag : erase_error_flag);

  // Next-state logic: controller, flags and read path
  always_comb
  begin
    next_state = state;
    next_op_erase = op_erase;
    next_op_blank = op_blank;
    next_active_bank = active_bank;
    next_erase_suspended_flag = erase_suspended_flag;
    next_program_suspended_flag = program_suspended_flag;
    next_supply_error_flag = supply_error_flag & ~cmd_clear_status;
    next_protection_error_flag = protection_error_flag & ~cmd_clear_status;
    next_erase_error_flag = erase_error_flag & ~cmd_clear_status;
    next_program_error_flag = program_error_flag & ~cmd_clear_status;
    next_engine_start = 1'b0;
    next_engine_suspend = 1'b0;
    next_engine_resume = 1'b0;
    // Hardware sets win over a clear in the same cycle
    if (erase_fail_max)
      next_erase_error_flag = 1'b1;
    if (blank_word_valid && op_blank && blank_word != flash_status_pkg::ERASED_WORD)
      next_erase_error_flag = 1'b1;
    if (program_fail_max)
      next_program_error_flag = 1'b1;
    if (program_overwrite_attempt && programming_supply_high_level)
      next_program_error_flag = 1'b1;
    case (state)
      flash_status_pkg::ST_IDLE:
      begin
        if (start_req && !start_blocked)
        begin
          // Supply is looked at here only, never during the operation
          if (!supply_above_lockout)
            next_supply_error_flag = 1'b1;
          else if (target_block_locked && !cmd_blank_check)
            next_protection_error_flag = 1'b1;
          else
          begin
            next_state = flash_status_pkg::ST_BUSY;
            next_op_erase = ~cmd_program;
            next_op_blank = cmd_blank_check;
            next_active_bank = cmd_bank;
            next_engine_start = 1'b1;
          end
        end
      end
      flash_status_pkg::ST_BUSY:
      begin
        if (engine_done)
          next_state = flash_status_pkg::ST_IDLE;
        else if (cmd_suspend)
        begin
          next_state = flash_status_pkg::ST_SUSP_PEND;
          next_engine_suspend = 1'b1;
        end
      end
      flash_status_pkg::ST_SUSP_PEND:
      begin
        // The engine may still finish rather than pause
        if (engine_done)
          next_state = flash_status_pkg::ST_IDLE;
        else if (engine_paused)
        begin
          next_state = flash_status_pkg::ST_SUSPENDED;
          if (op_erase)
            next_erase_suspended_flag = 1'b1;
          else
            next_program_suspended_flag = 1'b1;
        end
      end
      flash_status_pkg::ST_SUSPENDED:
      begin
        if (cmd_resume)
        begin
          next_state = flash_status_pkg::ST_BUSY;
          next_erase_suspended_flag = 1'b0;
          next_program_suspended_flag = 1'b0;
          next_engine_resume = 1'b1;
        end
      end
      default:
        next_state = flash_status_pkg::ST_IDLE;
    endcase
    if (cmd_read_array)
      next_status_mode = 1'b0;
    else if (start_req || cmd_read_status)
      next_status_mode = 1'b1;
    else
      next_status_mode = status_mode;
    next_read_active_q = read_active;
    next_read_word = read_word;
    // Snapshot at the start of the cycle so the value cannot tear mid-read
    if (read_start)
      next_read_word = status_mode ? {flash_status_pkg::STATUS_UPPER, status_now}
        : array_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= flash_status_pkg::ST_IDLE;
      op_erase <= 1'b0;
      op_blank <= 1'b0;
      active_bank <= '0;
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
      erase_error_flag <= 1'b0;
      program_error_flag <= 1'b0;
      supply_error_flag <= 1'b0;
      protection_error_flag <= 1'b0;
      status_mode <= 1'b0;
      read_active_q <= 1'b0;
      read_word <= flash_status_pkg::DATA_RESET;
      engine_start <= 1'b0;
      engine_suspend <= 1'b0;
      engine_resume <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op_erase <= next_op_erase;
      op_blank <= next_op_blank;
      active_bank <= next_active_bank;
      erase_suspended_flag <= next_erase_suspended_flag;
      program_suspended_flag <= next_program_suspended_flag;
      erase_error_flag <= next_erase_error_flag;
      program_error_flag <= next_program_error_flag;
      supply_error_flag <= next_supply_error_flag;
      protection_error_flag <= next_protection_error_flag;
      status_mode <= next_status_mode;
      read_active_q <= next_read_active_q;
      read_word <= next_read_word;
      engine_start <= next_engine_start;
      engine_suspend <= next_engine_suspend;
      engine_resume <= next_engine_resume;
    end
  end

  assign dq_out = read_word;
  assign dq_oe = read_active & read_active_q;
  assign engine_is_erase = op_erase;
  assign engine_is_blank_check = op_blank;
  assign program_erase_status = status_now;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_start_goes_busy: assert property (
    engine_start |-> !program_erase_status[7])
    else $error("ready high while operation started");
  a_suspend_wait_pause: assert property (
    (state == flash_status_pkg::ST_SUSP_PEND) && !engine_paused && !engine_done
    |=> !program_erase_status[7])
    else $error("ready rose before engine paused");
  a_erase_susp_set: assert property (
    (state == flash_status_pkg::ST_SUSP_PEND) && engine_paused && !engine_done && op_erase
    |=> program_erase_status[6] && program_erase_status[7])
    else $error("erase suspended flag not set on pause");
  a_resume_clears: assert property (
    (state == flash_status_pkg::ST_SUSPENDED) && cmd_resume
    |=> !program_erase_status[6] && !program_erase_status[2] && engine_resume)
    else $error("resume did not clear suspend flags");
  a_erase_err_set: assert property (
    erase_fail_max |=> program_erase_status[5])
    else $error("erase error flag missing");
  a_blank_err_set: assert property (
    blank_word_valid && op_blank && blank_word != flash_status_pkg::ERASED_WORD
    |=> program_erase_status[5])
    else $error("blank check mismatch not flagged");
  a_err_sticky_hold: assert property (
    erase_error_flag && !cmd_clear_status |=> erase_error_flag [*2] or
      (erase_error_flag ##1 $fell(erase_error_flag)))
    else $error("erase error dropped without clear");
  a_blocked_no_start: assert property (
    (state == flash_status_pkg::ST_IDLE) && cmd_program && program_error_flag
    |=> !engine_start && state == flash_status_pkg::ST_IDLE)
    else $error("program ran despite program error");
  a_overwrite_low_supply: assert property (
    program_overwrite_attempt && !programming_supply_high_level && !program_fail_max
    && !program_error_flag |=> !program_erase_status[4])
    else $error("overwrite flagged at low supply");
  a_supply_refuse: assert property (
    (state == flash_status_pkg::ST_IDLE) && start_req && !start_blocked
    && !supply_above_lockout |=> program_erase_status[3] && !engine_start ##1 !engine_start)
    else $error("low supply not refused");
  a_protect_abort: assert property (
    (state == flash_status_pkg::ST_IDLE) && start_req && !start_blocked && supply_above_lockout
    && target_block_locked && !cmd_blank_check |=> program_erase_status[1] && !engine_start)
    else $error("locked block not refused");
  a_bank_flag_busy: assert property (
    !program_erase_status[7] && !buffered_factory_program_mode
    |-> program_erase_status[0] == (bus_bank != active_bank))
    else $error("bank write flag wrong");
  a_latch_hold_read: assert property (
    read_active_q && read_active && $past(read_active_q) |-> $stable(dq_out))
    else $error("status changed during read");

  c_erase_suspend_resume: cover property (
    (state == flash_status_pkg::ST_SUSPENDED) && op_erase ##1 cmd_resume);
  c_program_done: cover property (engine_start && !op_erase ##[1:50] engine_done);
  c_clear_status: cover property (program_error_flag && cmd_clear_status);
  c_status_read: cover property (read_start && status_mode);
endmodule // flash_status_register
`default_nettype wire

// file: flash_status_pkg.sv
// Constants and types shared by the flash status register block
package flash_status_pkg;
  // Bit positions inside the status byte
  localparam int unsigned BIT_READY = 7;
  localparam int unsigned BIT_ERASE_SUSP = 6;
  localparam int unsigned BIT_ERASE_ERR = 5;
  localparam int unsigned BIT_PROG_ERR = 4;
  localparam int unsigned BIT_SUPPLY_ERR = 3;
  localparam int unsigned BIT_PROG_SUSP = 2;
  localparam int unsigned BIT_PROTECT_ERR = 1;
  localparam int unsigned BIT_BANK_WRITE = 0;
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BANK_W = 4;
  // Status after reset: controller ready, every other flag low
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // Value of an erased word checked by blank check
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Upper data lanes during a status read
  localparam logic [7:0] STATUS_UPPER = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_SUSP_PEND = 4'b0100,
    ST_SUSPENDED = 4'b1000
  } ctrl_state_t;
endpackage

// file: flash_engine_model.sv
// Behavioural program/erase engine that answers the status block
`timescale 1ns/1ns
`default_nettype none
module flash_engine_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic engine_start,
  input wire logic engine_suspend,
  input wire logic engine_resume,
  input wire logic [7:0] run_len,
  input wire logic [7:0] pause_len,
  output logic engine_done,
  output logic engine_paused
);
  logic [7:0] cnt;
  logic [7:0] pcnt;
  logic busy;
  logic hold;

  // A long pause_len lets the operation finish before it can pause
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 8'h00;
      pcnt <= 8'h00;
      busy <= 1'b0;
      hold <= 1'b0;
      engine_done <= 1'b0;
      engine_paused <= 1'b0;
    end
    else
    begin
      engine_done <= 1'b0;
      engine_paused <= 1'b0;
      if (engine_start)
      begin
        cnt <= run_len;
        busy <= 1'b1;
        hold <= 1'b0;
        pcnt <= 8'h00;
      end
      else if (engine_resume)
        hold <= 1'b0;
      else if (busy)
      begin
        if (pcnt != 8'h00)
          pcnt <= pcnt - 8'h01;
        if (pcnt == 8'h01)
        begin
          engine_paused <= 1'b1;
          hold <= 1'b1;
        end
        if (engine_suspend)
          pcnt <= pause_len;
        if (!hold)
          cnt <= cnt - 8'h01;
        if (!hold && cnt == 8'h01)
        begin
          engine_done <= 1'b1;
          busy <= 1'b0;
          pcnt <= 8'h00;
        end
      end
    end
  end
endmodule // flash_engine_model
`default_nettype wire

// file: flash_status_register_tb.sv
// Self-checking bench for the flash status register
`timescale 1ns/1ns
`default_nettype none
module flash_status_register_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_program = 1'b0, cmd_erase = 1'b0, cmd_blank_check = 1'b0, cmd_suspend = 1'b0;
  logic cmd_resume = 1'b0, cmd_clear_status = 1'b0, cmd_read_array = 1'b0;
  logic cmd_read_status = 1'b0, target_block_locked = 1'b0, supply_above_lockout = 1'b1;
  logic programming_supply_high_level = 1'b0, erase_fail_max = 1'b0, program_fail_max = 1'b0;
  logic program_overwrite_attempt = 1'b0, blank_word_valid = 1'b0, bfp_word_ready = 1'b0;
  logic buffered_factory_program_mode = 1'b0, ce_n = 1'b1, oe_n = 1'b1;
  logic [3:0] cmd_bank = 4'h3, bus_bank = 4'h3;
  logic [15:0] blank_word = 16'hFFFF, array_data = 16'hA5C3;
  logic [7:0] run_len = 8'h14, pause_len = 8'h05;
  logic engine_done, engine_paused, dq_oe, engine_start, engine_is_erase, engine_is_blank_check;
  logic engine_suspend, engine_resume;
  logic [15:0] dq_out;
  logic [7:0] st;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  typedef enum int {P_PROGRAM, P_ERASE, P_BLANK, P_SUSPEND, P_RESUME, P_CLEAR, P_READ_ARRAY,
    P_READ_STATUS, P_ERASE_FAIL, P_PROG_FAIL, P_OVERWRITE, P_BLANK_VALID} pulse_sel_t;

  flash_status_register u_flash_status_register (.clk(clk), .reset_n(reset_n),
    .cmd_program(cmd_program), .cmd_erase(cmd_erase), .cmd_blank_check(cmd_blank_check),
    .cmd_suspend(cmd_suspend), .cmd_resume(cmd_resume), .cmd_clear_status(cmd_clear_status),
    .cmd_read_array(cmd_read_array), .cmd_read_status(cmd_read_status), .cmd_bank(cmd_bank),
    .target_block_locked(target_block_locked), .supply_above_lockout(supply_above_lockout),
    .programming_supply_high_level(programming_supply_high_level),
    .engine_done(engine_done), .engine_paused(engine_paused), .erase_fail_max(erase_fail_max),
    .program_fail_max(program_fail_max), .program_overwrite_attempt(program_overwrite_attempt),
    .blank_word_valid(blank_word_valid), .blank_word(blank_word),
    .buffered_factory_program_mode(buffered_factory_program_mode),
    .bfp_word_ready(bfp_word_ready), .ce_n(ce_n), .oe_n(oe_n), .bus_bank(bus_bank),
    .array_data(array_data), .dq_out(dq_out), .dq_oe(dq_oe), .engine_start(engine_start),
    .engine_is_erase(engine_is_erase), .engine_is_blank_check(engine_is_blank_check),
    .engine_suspend(engine_suspend), .engine_resume(engine_resume),
    .program_erase_status(st));

  flash_engine_model u_flash_engine_model (.clk(clk), .reset_n(reset_n),
    .engine_start(engine_start), .engine_suspend(engine_suspend),
    .engine_resume(engine_resume), .run_len(run_len), .pause_len(pause_len),
    .engine_done(engine_done), .engine_paused(engine_paused));

  initial
    forever #20 clk = ~clk;

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Selected by name, since a ref argument cannot take a nonblocking write
  task automatic drive_pulse(input pulse_sel_t sel, input logic v);
    case (sel)
      P_PROGRAM: cmd_program <= v;
      P_ERASE: cmd_erase <= v;
      P_BLANK: cmd_blank_check <= v;
      P_SUSPEND: cmd_suspend <= v;
      P_RESUME: cmd_resume <= v;
      P_CLEAR: cmd_clear_status <= v;
      P_READ_ARRAY: cmd_read_array <= v;
      P_READ_STATUS: cmd_read_status <= v;
      P_ERASE_FAIL: erase_fail_max <= v;
      P_PROG_FAIL: program_fail_max <= v;
      P_OVERWRITE: program_overwrite_attempt <= v;
      default: blank_word_valid <= v;
    endcase
  endtask

  task automatic pulse(input pulse_sel_t sel);
    @(posedge clk);
    drive_pulse(sel, 1'b1);
    @(posedge clk);
    drive_pulse(sel, 1'b0);
    #1;
  endtask

  // Polls like a host: flags are only trusted once ready is back
  task automatic wait_ready();
    int i;
    i = 0;
    while (st[7] !== 1'b1 && i < 300)
    begin
      @(posedge clk);
      #1;
      i++;
    end
  endtask

  task automatic read_word(input logic [15:0] exp, input int hold);
    @(posedge clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    repeat (hold) @(posedge clk);
    #1;
    check("dq_oe", dq_oe, 1'b1);
    check("dq_out", dq_out, exp);
    @(posedge clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    #1;
  endtask

  task automatic t_busy();
    pulse(P_ERASE);
    check("start", engine_start, 1'b1);
    check("is erase", engine_is_erase, 1'b1);
    check("busy here", st, 8'h00);
    @(posedge clk);
    bus_bank <= 4'h5;
    #1;
    check("busy other", st, 8'h01);
    @(posedge clk);
    buffered_factory_program_mode <= 1'b1;
    bfp_word_ready <= 1'b1;
    #1;
    check("word ready", st, 8'h00);
    @(posedge clk);
    bfp_word_ready <= 1'b0;
    #1;
    check("word not ready", st, 8'h01);
    @(posedge clk);
    buffered_factory_program_mode <= 1'b0;
    bus_bank <= 4'h3;
    // Read spans the end of the operation, so the latched word must hold
    read_word(16'h0000, 25);
    check("idle", st, 8'h80);
    pulse(P_READ_ARRAY);
    read_word(16'hA5C3, 2);
    pulse(P_READ_STATUS);
    read_word(16'h0080, 2);
  endtask

  task automatic t_suspend(input logic erase, input logic [7:0] flag, input logic [7:0] plen);
    @(posedge clk);
    run_len <= 8'h28;
    pause_len <= plen;
    if (erase)
      pulse(P_ERASE);
    else
      pulse(P_PROGRAM);
    if (plen == 8'h05)
      repeat (3) @(posedge clk);
    else
      run_len <= 8'h04;
    pulse(P_SUSPEND);
    check("suspend out", engine_suspend, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check("pausing", st[7], 1'b0);
    wait_ready();
    check("suspended", st, 8'h80 | flag);
    if (flag != 8'h00)
    begin
      pulse(P_RESUME);
      check("resumed", st, 8'h00);
      check("resume out", engine_resume, 1'b1);
      wait_ready();
    end
  endtask

  task automatic t_errors();
    run_len <= 8'h06;
    pulse(P_ERASE);
    pulse(P_ERASE_FAIL);
    wait_ready();
    check("erase err", st, 8'hA0);
    pulse(P_ERASE);
    check("erase refused", engine_start, 1'b0);
    pulse(P_CLEAR);
    check("cleared", st, 8'h80);
    pulse(P_PROGRAM);
    pulse(P_PROG_FAIL);
    wait_ready();
    check("prog err", st, 8'h90);
    pulse(P_PROGRAM);
    check("prog refused", engine_start, 1'b0);
    pulse(P_CLEAR);
    pulse(P_PROGRAM);
    pulse(P_OVERWRITE);
    wait_ready();
    check("overwrite low", st, 8'h80);
    @(posedge clk);
    programming_supply_high_level <= 1'b1;
    pulse(P_PROGRAM);
    pulse(P_OVERWRITE);
    wait_ready();
    check("overwrite high", st, 8'h90);
    pulse(P_CLEAR);
    pulse(P_BLANK);
    check("is blank", engine_is_blank_check, 1'b1);
    pulse(P_BLANK_VALID);
    check("blank ok", st, 8'h00);
    @(posedge clk);
    blank_word <= 16'hFFFE;
    pulse(P_BLANK_VALID);
    check("blank bad", st, 8'h20);
    wait_ready();
    pulse(P_CLEAR);
    @(posedge clk);
    supply_above_lockout <= 1'b0;
    pulse(P_PROGRAM);
    check("low supply", engine_start, 1'b0);
    check("low supply st", st, 8'h88);
    @(posedge clk);
    supply_above_lockout <= 1'b1;
    pulse(P_ERASE);
    check("supply sticky", engine_start, 1'b0);
    pulse(P_CLEAR);
    pulse(P_ERASE);
    @(posedge clk);
    supply_above_lockout <= 1'b0;
    wait_ready();
    check("mid-op supply", st, 8'h80);
    @(posedge clk);
    supply_above_lockout <= 1'b1;
    target_block_locked <= 1'b1;
    pulse(P_ERASE);
    check("locked", st, 8'h82);
    check("locked start", engine_start, 1'b0);
  endtask

  // Sticky errors drop on a hardware reset as well as on a clear
  task automatic t_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    target_block_locked <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("reset sticky", st, 8'h80);
    pulse(P_ERASE);
    check("start after reset", engine_start, 1'b1);
    wait_ready();
    check("done after reset", st, 8'h80);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("reset", st, 8'h80);
    t_busy();
    t_suspend(1'b1, 8'h40, 8'h05);
    t_suspend(1'b0, 8'h04, 8'h05);
    t_suspend(1'b1, 8'h00, 8'h1E);
    t_errors();
    t_reset();
    end_sim();
  end
endmodule // flash_status_register_tb
`default_nettype wire
